// ==== frc_timer.sv ====
// Free-running 16-bit counter with two 8-bit edge capture channels, APB slave.
// Assumes a 10 MHz pclk that also serves as the capture timebase, and an APB3 master.
//
// How it works
// R1 - Sixteen-bit free up-counter is common time base
// R2 - Low read latches high byte for coherence
// R3 - Low write staged; high write loads both
// R4 - Software accesses low byte before high byte
// R5 - Periodic request every 4096 counts
// R6 - Request when counter wraps to zero
// R7 - Two channels, separate rise and fall registers
// R8 - Each capture register requests on load
// R9 - Hold off: every edge overwrites capture
// R10 - Hold on: first edge kept until read
// R11 - Window select picks counter bits n+7..n
// R12 - Join: channel 1 stores upper byte
// R13 - Capture flags set by event, write-one clears
// R14 - Capture request gated by its enable bit
// R15 - Inputs synchronised, edges from successive samples
`default_nettype none

module frc_timer #(
  parameter int ADDR_W = 8  // APB address width
) (
  // Clock, reset and freeze
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Capture pins
  input  wire logic              capture_input_zero,
  input  wire logic              capture_input_one,
  // Requests
  output logic                   periodic_irq,
  output logic                   overflow_irq,
  output logic      [3:0]        capture_irq
);

  // Slot count; the slot order also fixes the bit order of flags and requests
  localparam int NS = frc_pkg::NUM_SLOTS;

  // Bus handshake state
  logic              rd_valid_r;  // prdata holds the answer for this transfer
  logic [5:0]        idx;         // Register index from the address
  logic              aligned;     // Word aligned access
  logic              addr_hit;    // Address maps to a register
  logic              wr_fire;     // Write takes effect this edge
  logic              rd_fire;     // Read completes this edge
  logic              rd_load;     // Answer is captured this edge
  logic [7:0]        rd_mux;      // Selected read byte

  // Timer state
  logic [15:0]       cnt_r;       // Free-running counter
  logic [7:0]        stage_lo_r;  // Staged low byte for writes
  logic [7:0]        hold_hi_r;   // High byte caught on a low read
  logic [7:0]        cfg_r;       // Configuration byte
  logic [7:0]        ien_r;       // Capture enables, low nibble used
  logic [NS-1:0]     cstat_r;     // Capture event flags
  logic [1:0]        tstat_r;     // Periodic and overflow flags
  logic              cnt_load;    // High byte write loads counter
  logic              per_hit;     // Periodic boundary this cycle
  logic              ovf_hit;     // Wrap this cycle
  frc_pkg::frc_cfg_type cfg;      // Configuration view

  // Capture plumbing
  frc_pkg::frc_edge_type edge0;   // Channel 0 edges
  frc_pkg::frc_edge_type edge1;   // Channel 1 edges
  logic [15:0]       shifted;     // Counter moved down by the window select
  logic [7:0]        win8;        // Selected eight counter bits
  logic [NS-1:0]     slot_hit;    // Qualifying edge per slot
  logic [NS-1:0]     slot_load;   // Slot stored a new value
  logic [NS-1:0]     slot_rd;     // Slot read completed
  logic [7:0]        slot_data [NS];
  logic [7:0]        slot_val  [NS];

  assign cfg.hold  = cfg_r[frc_pkg::CFG_HOLD_BIT];
  assign cfg.presc = cfg_r[frc_pkg::CFG_PRESC_LSB +: 3];
  assign cfg.wide_capture_join = cfg_r[frc_pkg::CFG_JOIN_BIT];

  // Address decode; offsets are indexes, so the byte address drops two bits
  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  always_comb begin
    addr_hit = 1'b0;
    // Address bits above the byte range must be zero; a shift stays legal at any width
    if (aligned && (paddr >> 8) == '0) begin
      unique case (idx)
        frc_pkg::IDX_CNT_LO, frc_pkg::IDX_CNT_HI,
        frc_pkg::IDX_C0R, frc_pkg::IDX_C1R, frc_pkg::IDX_C0F, frc_pkg::IDX_C1F,
        frc_pkg::IDX_CFG, frc_pkg::IDX_IEN, frc_pkg::IDX_CSTAT,
        frc_pkg::IDX_TSTAT: addr_hit = 1'b1;
        default:            addr_hit = 1'b0;
      endcase
    end
  end

  // Answer is ready once prdata was caught in an enabled cycle
  // Zero wait states at full rate; a setup cycle spent frozen costs one extra
  // access cycle, since the answer is only caught while clk_en is high
  assign pready  = penable & rd_valid_r & clk_en;
  assign pslverr = pready & ~addr_hit;
  assign wr_fire = psel & pready & pwrite & addr_hit;
  assign rd_fire = psel & pready & ~pwrite & addr_hit;
  assign rd_load = psel & clk_en & ~rd_valid_r;

  // Tracks whether the read answer of the current transfer is captured
  // Cleared at the access edge so a back-to-back setup catches fresh data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_r <= 1'b0;
    end else if (clk_en) begin
      if (pready) begin
        rd_valid_r <= 1'b0;
      end else if (psel) begin
        rd_valid_r <= 1'b1;
      end
    end
  end

  // Read multiplexer; reserved bits and unmapped addresses read zero
  // Writes select zero too, so prdata never shows a stale register
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      frc_pkg::IDX_CNT_LO: rd_mux = cnt_r[7:0];
      frc_pkg::IDX_CNT_HI: rd_mux = hold_hi_r;    // [R2]
      frc_pkg::IDX_C0R:    rd_mux = slot_val[0];
      frc_pkg::IDX_C0F:    rd_mux = slot_val[1];
      frc_pkg::IDX_C1R:    rd_mux = slot_val[2];
      frc_pkg::IDX_C1F:    rd_mux = slot_val[3];
      frc_pkg::IDX_CFG:    rd_mux = {cfg_r[7:3], 3'h0};
      frc_pkg::IDX_IEN:    rd_mux = {4'h0, ien_r[3:0]};
      frc_pkg::IDX_CSTAT:  rd_mux = {4'h0, cstat_r};
      frc_pkg::IDX_TSTAT:  rd_mux = {6'h00, tstat_r};
      default:             rd_mux = 8'h00;
    endcase
    if (!addr_hit || pwrite) begin
      rd_mux = 8'h00;
    end
  end

  // Read data register, caught at the first enabled cycle of the transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_load) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  // High byte is caught together with the low byte answer
  // A high read without a fresh low read returns whatever was caught last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_hi_r <= 8'h00;
    end else if (rd_load && !pwrite && addr_hit && idx == frc_pkg::IDX_CNT_LO) begin
      hold_hi_r <= cnt_r[15:8];  // [R2] [R4]
    end
  end

  // Low byte writes are only staged until the high byte arrives
  // A high write with no fresh low write reuses the last staged byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_lo_r <= 8'h00;
    end else if (wr_fire && idx == frc_pkg::IDX_CNT_LO) begin
      stage_lo_r <= pwdata[7:0];  // [R3] [R4]
    end
  end

  assign cnt_load = wr_fire & (idx == frc_pkg::IDX_CNT_HI);

  // Free-running counter; a high byte write replaces one count step
  // It wraps through zero by itself; that wrap is what the overflow event reports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= frc_pkg::CNT_RESET;
    end else if (clk_en) begin
      if (cnt_load) begin
        cnt_r <= {pwdata[7:0], stage_lo_r};  // [R3]
      end else begin
        cnt_r <= cnt_r + 16'h0001;  // [R1]
      end
    end
  end

  // Counter events fire on the step that leaves the boundary value
  assign per_hit = ~cnt_load & (&cnt_r[frc_pkg::PERIOD_BITS-1:0]);  // [R5]
  assign ovf_hit = ~cnt_load & (&cnt_r);                            // [R6]

  // Request pulses, registered so they line up with the flag setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else if (clk_en) begin
      periodic_irq <= per_hit;  // [R5]
      overflow_irq <= ovf_hit;  // [R6]
    end
  end

  // Counter event flags; a set in the clearing cycle wins
  // Zero bits in the clearing write leave their flag alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstat_r <= 2'h0;
    end else if (clk_en) begin
      tstat_r <= (tstat_r & ~((wr_fire && idx == frc_pkg::IDX_TSTAT) ? pwdata[1:0] : 2'h0))
                 | {ovf_hit, per_hit};
    end
  end

  // Configuration and enable registers
  // Reserved bits are stored as zero so they always read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= frc_pkg::CFG_RESET;
      ien_r <= frc_pkg::IEN_RESET;
    end else if (wr_fire) begin
      if (idx == frc_pkg::IDX_CFG) begin
        cfg_r <= {pwdata[7:3], 3'h0};
      end
      if (idx == frc_pkg::IDX_IEN) begin
        ien_r <= {4'h0, pwdata[3:0]};
      end
    end
  end

  // Input synchronisers and edge detectors
  // Both pins idle low after reset, matching the reset state of each chain
  frc_edge_sync u_sync0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .pin      (capture_input_zero),
    .edge_out (edge0)
  );  // [R15]

  frc_edge_sync u_sync1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .pin      (capture_input_one),
    .edge_out (edge1)
  );  // [R15]

  // Window select; a barrel shift is cheaper than an eight-way byte mux here
  assign shifted = cnt_r >> cfg.presc;  // [R11]
  assign win8    = shifted[7:0];        // [R11]

  // Slot inputs; joined mode ignores the second pin entirely
  // and bypasses the window, storing the plain low and high counter bytes
  always_comb begin
    slot_hit[0]  = edge0.rise;  // [R7]
    slot_hit[1]  = edge0.fall;  // [R7]
    slot_hit[2]  = cfg.wide_capture_join ? edge0.rise : edge1.rise;  // [R12]
    slot_hit[3]  = cfg.wide_capture_join ? edge0.fall : edge1.fall;  // [R12]
    slot_data[0] = cfg.wide_capture_join ? cnt_r[7:0] : win8;        // [R12] [R11]
    slot_data[1] = cfg.wide_capture_join ? cnt_r[7:0] : win8;
    slot_data[2] = cfg.wide_capture_join ? cnt_r[15:8] : win8;       // [R12]
    slot_data[3] = cfg.wide_capture_join ? cnt_r[15:8] : win8;
  end

  // Four capture registers, each re-armed by a read of itself
  for (genvar s = 0; s < NS; s++) begin : g_slot
    assign slot_rd[s] = rd_fire & (idx == frc_pkg::SLOT_IDX[s]);  // [R10]
    frc_capture_slot #(
      .W (8)
    ) u_slot (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .hit      (slot_hit[s]),
      .data     (slot_data[s]),
      .hold     (cfg.hold),
      .read_ack (slot_rd[s]),
      .value    (slot_val[s]),
      .loaded   (slot_load[s])
    );  // [R9] [R10]
  end

  // Capture flags; a load in the same cycle as a write-one clear stays set
  // In joined mode the channel 1 flags follow channel 0 edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cstat_r <= 4'h0;
    end else if (clk_en) begin
      cstat_r <= (cstat_r & ~((wr_fire && idx == frc_pkg::IDX_CSTAT) ? pwdata[3:0] : 4'h0))
                 | slot_load;  // [R13] [R8]
    end
  end

  // Per-slot requests only where enabled
  // Level requests: each stays up until its flag or its enable is cleared
  assign capture_irq = cstat_r & ien_r[3:0];  // [R14] [R8]

endmodule : frc_timer

`default_nettype wire

// ==== frc_pkg.sv ====
// Shared constants and types for the free-running edge capture timer.
// Assumes a single clock domain; PCLK_HZ, CNT_W and the TSTAT bit positions are not used by the timer or its helpers.
`default_nettype none

package frc_pkg;

  // Register indexes; byte address on the bus is four times the index
  localparam logic [5:0] IDX_CNT_LO = 6'h20;  // Counter low byte
  localparam logic [5:0] IDX_CNT_HI = 6'h21;  // Counter high byte
  localparam logic [5:0] IDX_C0R    = 6'h22;  // Channel 0 rising capture
  localparam logic [5:0] IDX_C1R    = 6'h23;  // Channel 1 rising capture
  localparam logic [5:0] IDX_C0F    = 6'h24;  // Channel 0 falling capture
  localparam logic [5:0] IDX_C1F    = 6'h25;  // Channel 1 falling capture
  localparam logic [5:0] IDX_CFG    = 6'h2a;  // Capture configuration
  localparam logic [5:0] IDX_IEN    = 6'h2b;  // Capture interrupt enable
  localparam logic [5:0] IDX_CSTAT  = 6'h2c;  // Capture event status
  localparam logic [5:0] IDX_TSTAT  = 6'h2d;  // Counter event status

  // Capture slot order: bit 0 ch0 rise, 1 ch0 fall, 2 ch1 rise, 3 ch1 fall
  localparam int          NUM_SLOTS = 4;
  localparam logic [3:0][5:0] SLOT_IDX = {IDX_C1F, IDX_C1R, IDX_C0F, IDX_C0R};

  // Configuration field positions
  localparam int CFG_HOLD_BIT  = 7;  // Keep earliest edge
  localparam int CFG_PRESC_LSB = 4;  // Byte-window select, three bits
  localparam int CFG_JOIN_BIT  = 3;  // Wide capture join
  localparam int TSTAT_PER_BIT = 0;  // Periodic event flag
  localparam int TSTAT_OVF_BIT = 1;  // Overflow event flag

  // Reset values
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [7:0]  IEN_RESET  = 8'h00;
  localparam logic [7:0]  CAP_RESET  = 8'h00;

  // Timing: counter advances once per enabled pclk cycle
  localparam int PCLK_HZ         = 10_000_000;
  localparam int PERIOD_TIME_US  = 1024;  // Periodic interval at the reference rate
  localparam int REF_CLK_MHZ     = 4;     // Reference timebase rate
  localparam int PERIOD_COUNTS   = PERIOD_TIME_US * REF_CLK_MHZ;
  localparam int PERIOD_BITS     = $clog2(PERIOD_COUNTS);
  localparam int OVF_TIME_NS     = 16_384_000;  // Wrap interval at the reference rate
  localparam int OVF_COUNTS      = OVF_TIME_NS * REF_CLK_MHZ / 1000;
  localparam int CNT_W           = $clog2(OVF_COUNTS);

  // Unpacked view of the configuration byte
  typedef struct packed {
    logic       hold;   // Keep earliest edge
    logic [2:0] presc;  // Byte-window select
    logic       wide_capture_join;  // Joins both channels into one wide capture
  } frc_cfg_type;

  // Edge pulses from one input
  typedef struct packed {
    logic rise;
    logic fall;
  } frc_edge_type;

endpackage : frc_pkg

`default_nettype wire

// ==== frc_edge_sync.sv ====
// Two-flop synchroniser plus edge detector for one capture input.
// Assumes the input is asynchronous; edges come out one enabled pclk cycle wide.
`default_nettype none

module frc_edge_sync (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clk_en,
  // Raw pin and edge pulses
  input  wire logic          pin,
  output frc_pkg::frc_edge_type edge_out
);

  logic meta_r;  // First stage, read only by the second
  logic sync_r;  // Synchronised level
  logic prev_r;  // Previous synchronised level

  // Sampling chain; the extra stage gives the compare value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (clk_en) begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edge pulses from successive clean samples
  always_comb begin
    edge_out.rise = sync_r & ~prev_r;
    edge_out.fall = ~sync_r & prev_r;
  end

endmodule : frc_edge_sync

`default_nettype wire

// ==== frc_capture_slot.sv ====
// One capture register with its earliest-edge hold logic.
// Assumes the parent supplies the selected counter bits and a read strobe.
`default_nettype none

module frc_capture_slot #(
  parameter int W = 8  // Captured width
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  // Capture control
  input  wire logic         hit,       // Qualifying edge this cycle
  input  wire logic [W-1:0] data,      // Counter bits to store
  input  wire logic         hold,      // Keep earliest edge
  input  wire logic         read_ack,  // Register read completed
  // Results
  output logic      [W-1:0] value,
  output logic              loaded     // Pulse when a new value is stored
);

  logic full_r;  // Holds an unread value in keep-earliest mode

  // A new value is taken unless an unread earliest edge is being kept
  assign loaded = hit & (~hold | ~full_r);

  // Value storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= frc_pkg::CAP_RESET[W-1:0];
    end else if (clk_en && loaded) begin
      value <= data;
    end
  end

  // Arm tracking; a load in the read cycle wins so that edge is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_r <= 1'b0;
    end else if (clk_en) begin
      if (loaded) begin
        full_r <= 1'b1;
      end else if (read_ack || !hold) begin
        full_r <= 1'b0;
      end
    end
  end

endmodule : frc_capture_slot

`default_nettype wire

// ==== frc_timer_sva.sv ====
// Checker for the timer's bus answers, request pulses and capture enable gating.
// Assumes it is bound into frc_timer and sees nothing but that module's ports.
`default_nettype none

module frc_timer_sva #(
  parameter int ADDR_W = 8  // APB address width
) (
  // Clock, reset and freeze
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  // APB slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Capture pins
  input wire logic              capture_input_zero,
  input wire logic              capture_input_one,
  // Requests
  input wire logic              periodic_irq,
  input wire logic              overflow_irq,
  input wire logic [3:0]        capture_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access edge of a completed transfer
  wire done_w = psel && penable && pready;

  // A frozen cycle holds a pulse, so only an enabled edge must drop it
  a_ovf_single: assert property (overflow_irq && clk_en |=> !overflow_irq)
    else $error("overflow request longer than one cycle");
  a_per_single: assert property (periodic_irq && clk_en |=> !periodic_irq)
    else $error("periodic request longer than one cycle");
  // A wrap to zero also leaves a 4096 boundary, so both fire together
  a_ovf_with_per: assert property (overflow_irq |-> periodic_irq)
    else $error("overflow without periodic request");
  a_ready_access: assert property (pready |-> penable && clk_en)
    else $error("ready outside an enabled access phase");
  a_rdata_narrow: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  a_err_misalign: assert property (done_w && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not answered with error");
  a_err_rdata_zero: assert property (done_w && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("errored read returned data");
  // Clearing every enable must silence every capture request next cycle
  a_ien_gate: assert property (done_w && pwrite && paddr == 8'hac && pwdata[3:0] == 4'h0
    |=> capture_irq == 4'h0)
    else $error("capture request despite cleared enable");
endmodule : frc_timer_sva

bind frc_timer frc_timer_sva #(.ADDR_W(ADDR_W)) i_frc_timer_sva (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .capture_input_zero, .capture_input_one,
  .periodic_irq, .overflow_irq, .capture_irq
);

`default_nettype wire

// ==== frc_pins.sv ====
// Model of the external signal sources on both capture pins.
// Assumes the bench calls set_pin; levels change just after a rising pclk edge.
`default_nettype none

module frc_pins (
  // Launch clock
  input  wire logic pclk,
  // Capture pins
  output logic      pin0,
  output logic      pin1
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both pins idle low, so the first edge on each is a rise
  initial begin
    pin0 <= 1'b0;
    pin1 <= 1'b0;
  end

  // Pins are taken as synchronous, so levels change right after a rising edge
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge pclk);
    if (ch == 0) pin0 <= lvl;
    else pin1 <= lvl;
  endtask : set_pin
endmodule : frc_pins

`default_nettype wire

// ==== tb_frc_timer.sv ====
// Self-checking bench for frc_timer: counter access, periodic and wrap pulses, captures.
// Assumes frc_timer, frc_pins and the bound checker are compiled before it.
`default_nettype none

module tb_frc_timer;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk    = 1'b0;   // 10 MHz bus and timebase clock
  logic        presetn = 1'b0;   // Reset, active low
  logic        clk_en  = 1'b1;   // Freeze input, lowered in one scenario
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin0;
  logic        pin1;
  logic        per_irq;
  logic        ovf_irq;
  logic [3:0]  cap_irq;
  int          err_total = 0;
  int          n_tests   = 0;
  int          seed      = 32'hadd16dcc;
  int          cyc       = 0;    // Clock edges seen
  int          t_load    = 0;    // Edge count at which the counter was loaded
  int          v_load    = 0;    // Value then loaded
  logic [31:0] rd;               // Last read data
  logic        rerr;             // Last error response

  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  // Freeze input runs high except in the freeze scenario
  frc_timer i_frc_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_zero(pin0),
    .capture_input_one(pin1), .periodic_irq(per_irq), .overflow_irq(ovf_irq),
    .capture_irq(cap_irq));
  frc_pins i_frc_pins (.pclk(pclk), .pin0(pin0), .pin1(pin1));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    $display("Counts: %0d compared, %0d mismatched", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // One APB transfer; ready, read data and response are taken at the rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) chk("pready", 1, 0);
    rd = prdata;
    rerr = pslverr;
    if (w && a == 8'h84) t_load = cyc + 1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Low byte first on both read and write
  task automatic load(input int v);
    apb(1, 8'h80, v[7:0]);
    apb(1, 8'h84, v[15:8]);
    v_load = v & 32'hffff;
  endtask : load

  task automatic rd_cnt(output int v);
    int lo;
    apb(0, 8'h80, 8'h00);
    lo = rd[7:0];
    apb(0, 8'h84, 8'h00);
    v = {rd[7:0], lo[7:0]};
  endtask : rd_cnt

  // Pin edge plus the counter value the model expects at that moment
  task automatic hit(input int ch, input logic lvl, output int t);
    i_frc_pins.set_pin(ch, lvl);
    t = (v_load + cyc - t_load) & 32'hffff;
    repeat (8) @(posedge pclk);
  endtask : hit

  // Synchroniser latency leaves a few counts of slack in what is captured
  function automatic logic near(input logic [7:0] got, input int t, input int n);
    near = 1'b0;
    for (int d = 0; d < 7; d++) if (got === 8'(((t + d) & 32'hffff) >> n)) near = 1'b1;
  endfunction : near

  initial begin
    #(20_000 * 100);
    err_total++;
    wrap_up();
  end

  initial begin
    int t[4];
    int v, k, d0, m;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'ha8 + 8'(4 * i), 8'h00);
      chk("reset_value", 0, rd);
    end
    apb(0, 8'hfc, 8'h00);
    chk("unmapped_err", 1, rerr);
    chk("unmapped_data", 0, rd);
    apb(0, 8'h81, 8'h00);
    chk("misalign_err", 1, rerr);
    apb(1, 8'h88, 8'hff);
    apb(0, 8'h88, 8'h00);
    chk("capture_readonly", 0, rd);
    $display("Test done: registers");
    for (int i = 0; i < 4; i++) begin
      load(i == 0 ? 32'h12fe : $random(seed));
      rd_cnt(v);
      chk("cnt_coherent", 1, 32'(((v - v_load) & 32'hffff) < 12));
    end
    apb(1, 8'h80, 8'h00);
    repeat (20) @(posedge pclk);
    rd_cnt(v);
    chk("cnt_staged", 1, 32'(((v - v_load) & 32'hffff) < 60));
    load(32'h0100);
    clk_en <= 1'b0;
    repeat (50) @(posedge pclk);
    clk_en <= 1'b1;
    rd_cnt(v);
    chk("cnt_freeze", 1, 32'(((v - v_load) & 32'hffff) < 12));
    $display("Test done: counter access");
    for (int i = 0; i < 2; i++) begin
      load(i ? 32'hfff0 : 32'h0ff0);
      k = 0;
      do begin
        @(negedge pclk);
        k++;
      end while (per_irq !== 1'b1 && k < 40);
      chk("ovf_at_wrap", i, {31'h0, ovf_irq});
      if (i == 0) d0 = k;
      else chk("per_delay", d0, k);
    end
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (per_irq !== 1'b1 && k < 5000);
    chk("per_spacing", 4096, k);
    apb(0, 8'hb4, 8'h00);
    chk("tstat_set", 3, rd);
    apb(1, 8'hb4, 8'h03);
    apb(0, 8'hb4, 8'h00);
    chk("tstat_clear", 0, rd);
    $display("Test done: periodic and wrap");
    for (int n = 0; n < 8; n++) begin
      m = $random(seed) & 15;
      apb(1, 8'ha8, 8'(n << 4));
      apb(1, 8'hac, 8'(m));
      load($random(seed));
      for (int i = 0; i < 4; i++) hit(i % 2, i < 2, t[i]);
      for (int i = 0; i < 4; i++) begin
        apb(0, 8'h88 + 8'(4 * i), 8'h00);
        chk("cap_window", 1, 32'(near(rd[7:0], t[i], n)));
      end
      chk("cap_irq", m, {28'h0, cap_irq});
      apb(0, 8'hb0, 8'h00);
      chk("cap_flags", 15, rd);
      k = $random(seed) & 15;
      apb(1, 8'hb0, 8'(k));
      apb(0, 8'hb0, 8'h00);
      chk("flag_w1c", 15 & ~k, rd);
      apb(1, 8'hb0, 8'h0f);
    end
    $display("Test done: capture windows");
    apb(1, 8'ha8, 8'h00);
    hit(0, 1, t[0]);
    hit(0, 0, t[1]);
    hit(0, 1, t[2]);
    apb(0, 8'h88, 8'h00);
    chk("cap_newest", 1, 32'(near(rd[7:0], t[2], 0)));
    apb(1, 8'ha8, 8'h80);
    hit(0, 0, t[1]);
    hit(0, 1, t[0]);
    hit(0, 0, t[1]);
    hit(0, 1, t[2]);
    apb(0, 8'h88, 8'h00);
    chk("cap_first", 1, 32'(near(rd[7:0], t[0], 0)));
    hit(0, 0, t[1]);
    hit(0, 1, t[3]);
    apb(0, 8'h88, 8'h00);
    chk("cap_rearm", 1, 32'(near(rd[7:0], t[3], 0)));
    $display("Test done: edge hold");
    apb(1, 8'ha8, 8'h78);
    hit(0, 0, t[0]);
    hit(1, 1, t[1]);
    hit(0, 1, t[2]);
    hit(1, 0, t[3]);
    apb(0, 8'h90, 8'h00);
    chk("join_lo", 1, 32'(near(rd[7:0], t[0], 0)));
    apb(0, 8'h94, 8'h00);
    chk("join_hi_fall", 1, 32'(near(rd[7:0], t[0], 8)));
    apb(0, 8'h8c, 8'h00);
    chk("join_hi_rise", 1, 32'(near(rd[7:0], t[2], 8)));
    apb(1, 8'hac, 8'h0f);
    @(negedge pclk);
    chk("join_irq", 15, {28'h0, cap_irq});
    apb(1, 8'hac, 8'h00);
    @(negedge pclk);
    chk("ien_off", 0, {28'h0, cap_irq});
    $display("Test done: wide join");
    wrap_up();
  end
endmodule : tb_frc_timer

`default_nettype wire
